// ===== core/bank_ctl_if.sv
/*
  Carrier between the command decoder and each bank state machine.
  Assumes one instance per bank, all on the system clock.
*/
`timescale 1ns/1ps
interface bank_ctl_if;
  logic                            do_act;
  logic                            do_read;
  logic                            do_write;
  logic                            do_pre;
  logic                            auto_pre;
  logic                            end_burst;
  ddr_cmd_pkg::bank_state_type     state;

  modport ctl  (output do_act, do_read, do_write, do_pre, auto_pre, end_burst, input state);
  modport bank (input do_act, do_read, do_write, do_pre, auto_pre, end_burst, output state);
endinterface

// ===== core/ddr_bank_fsm.sv
/*
  One bank's state machine with its own tRP / tRCD / burst timer.
  Assumes the decoder only pulses commands legal for the present state.
*/
`timescale 1ns/1ps
module ddr_bank_fsm (
  // clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_rstn,
  // decoder side
  bank_ctl_if.bank   ctl
);
  import ddr_cmd_pkg::*;

  bank_state_type     state;
  logic [TMR_W-1:0]   tmr;
  logic               ap_pre;

  assign ctl.state = state;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state  <= BANK_IDLE;
      tmr    <= TMR_ZERO;
      ap_pre <= 1'b0;
    end else if (ctl.do_pre) begin
      state  <= BANK_PRECHARGING;
      tmr    <= TMR_W'(RP_CYC);
      ap_pre <= 1'b0;
    end else if (ctl.do_act) begin
      state <= BANK_ACTIVATING;
      tmr   <= TMR_W'(RCD_CYC);
    end else if (ctl.do_read || ctl.do_write) begin
      if (ctl.do_read) begin
        state <= ctl.auto_pre ? BANK_READ_AP : BANK_READ;
        tmr   <= TMR_W'(BURST_LEN / 2);
      end else begin
        state <= ctl.auto_pre ? BANK_WRITE_AP : BANK_WRITE;
        tmr   <= TMR_W'(BURST_LEN / 2 + WR_CYC);
      end
      ap_pre <= 1'b0;
    end else if (ctl.end_burst && state == BANK_READ) begin
      state <= BANK_ACTIVE;
      tmr   <= TMR_ZERO;
    end else if (tmr > TMR_ZERO) begin
      tmr <= tmr - TMR_W'(1);
    end else begin
      case (state)
        BANK_PRECHARGING: state <= BANK_IDLE;
        BANK_ACTIVATING:  state <= BANK_ACTIVE;
        BANK_READ,
        BANK_WRITE:       state <= BANK_ACTIVE;
        BANK_READ_AP,
        BANK_WRITE_AP: begin
          // access period ends; then tRP of the automatic precharge
          if (ap_pre) begin
            state  <= BANK_IDLE;
            ap_pre <= 1'b0;
          end else begin
            ap_pre <= 1'b1;
            tmr    <= TMR_W'(RP_CYC);
          end
        end
        default: state <= state;
      endcase
    end
  end

endmodule // ddr_bank_fsm

// ===== core/ddr_cke_cmd_fsm.sv
/*
  Command and state logic of a four-bank DDR SDRAM behind its command pins:
  clock-enable power modes, per-bank state, timed transient states.
  Assumes command pins come from another clock domain and are synchronised here,
  so every command is seen two cycles late, all consistently.
*/
`timescale 1ns/1ps
module ddr_cke_cmd_fsm (
  // clock and reset
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rstn,
  // command pins
  input  wire logic                           i_cke,
  input  wire logic                           i_cs_n,
  input  wire logic                           i_ras_n,
  input  wire logic                           i_cas_n,
  input  wire logic                           i_we_n,
  input  wire logic [1:0]                     i_bank_addr,
  input  wire logic [ddr_cmd_pkg::ADDR_W-1:0] i_addr,
  // state and status
  output logic [ddr_cmd_pkg::NUM_BANKS*4-1:0] o_bank_states,
  output ddr_cmd_pkg::glb_state_type          o_glb_state,
  output logic                                o_illegal,
  output logic                                o_illegal_seen,
  output logic                                o_read_ready
);
  import ddr_cmd_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int unsigned PIN_W = 5 + 2 + ADDR_W;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank_addr, i_addr};
      pin_sync <= pin_meta;
    end
  end

  logic              cke_cur;
  logic              cke_prev;
  logic [3:0]        cmd_bits;
  logic [1:0]        ba;
  logic [ADDR_W-1:0] addr;
  logic              is_nop;
  cmd_type           cmd;

  assign cke_cur  = pin_sync[PIN_W-1];
  assign cmd_bits = pin_sync[PIN_W-2 -: 4];
  assign ba       = pin_sync[ADDR_W +: 2];
  assign addr     = pin_sync[ADDR_W-1:0];
  assign cmd      = cmd_type'(cmd_bits[3] ? 4'h7 : cmd_bits);
  assign is_nop   = (cmd == CMD_NOP);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= cke_cur;
    end
  end

  // ************************************************************
  // bank machines
  // ************************************************************
  bank_ctl_if     bif [NUM_BANKS] ();
  bank_state_type bst [NUM_BANKS];
  logic [NUM_BANKS-1:0] b_idle;
  logic [NUM_BANKS-1:0] b_open;

  logic [NUM_BANKS-1:0] sel_act;
  logic [NUM_BANKS-1:0] sel_rd;
  logic [NUM_BANKS-1:0] sel_wr;
  logic [NUM_BANKS-1:0] sel_pre;
  logic [NUM_BANKS-1:0] sel_bst;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      assign bif[gi].do_act    = sel_act[gi];
      assign bif[gi].do_read   = sel_rd[gi];
      assign bif[gi].do_write  = sel_wr[gi];
      assign bif[gi].do_pre    = sel_pre[gi];
      assign bif[gi].auto_pre  = addr[AP_BIT];
      assign bif[gi].end_burst = sel_bst[gi];
      assign bst[gi]           = bif[gi].state;
      assign b_idle[gi]        = (bst[gi] == BANK_IDLE);
      assign b_open[gi]        = (bst[gi] == BANK_ACTIVE) || (bst[gi] == BANK_READ) ||
                                 (bst[gi] == BANK_WRITE);
      ddr_bank_fsm u_bank (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .ctl       (bif[gi])
      );
    end
  endgenerate

  // ************************************************************
  // global state and timer
  // ************************************************************
  glb_state_type     glb;
  logic [TMR_W-1:0]  gtmr;
  logic [7:0]        dll_cnt;
  logic [1:0]        last_rd_bank;
  logic              last_rd_valid;
  logic              all_idle;
  logic              cmd_en;
  logic              illegal;
  bank_state_type    cur;

  assign all_idle = &b_idle;
  assign cur      = bst[ba];
  // the bank table only applies with cke high at both edges
  assign cmd_en   = cke_prev && cke_cur && (glb == GLB_NORMAL);

  // ************************************************************
  // command decode
  // ************************************************************
  always_comb begin
    sel_act = '0;
    sel_rd  = '0;
    sel_wr  = '0;
    sel_pre = '0;
    sel_bst = '0;
    illegal = 1'b0;
    if (cke_prev && cke_cur && glb != GLB_NORMAL) begin
      // transient global states accept nothing but NOP
      illegal = !is_nop;
    end else if (cmd_en && !is_nop) begin
      case (cmd)
        CMD_ACT: begin
          if (cur == BANK_IDLE) sel_act[ba] = 1'b1;
          else illegal = 1'b1;
        end
        CMD_READ, CMD_WRITE: begin
          if (cur == BANK_ACTIVE || cur == BANK_READ || cur == BANK_WRITE) begin
            sel_rd[ba] = (cmd == CMD_READ);
            sel_wr[ba] = (cmd == CMD_WRITE);
          end else begin
            illegal = 1'b1;
          end
        end
        CMD_PRE: begin
          if (addr[AP_BIT]) begin
            // bank inputs ignored; transient banks make it illegal
            for (int i = 0; i < NUM_BANKS; i++) begin
              if (!(b_idle[i] || b_open[i])) illegal = 1'b1;
            end
            if (!illegal) sel_pre = ~b_idle;
          end else if (b_open[ba]) begin
            sel_pre[ba] = 1'b1;
          end else if (cur != BANK_IDLE) begin
            illegal = 1'b1;
          end
        end
        CMD_BST: begin
          if (last_rd_valid) sel_bst[last_rd_bank] = 1'b1;
          else illegal = 1'b1;
        end
        CMD_REF, CMD_MRS: begin
          illegal = !all_idle;
        end
        default: illegal = 1'b1;
      endcase
    end else if (cke_prev && !cke_cur && glb == GLB_NORMAL) begin
      // power-down entry needs NOP, self refresh needs refresh
      if (cmd == CMD_REF) illegal = !all_idle;
      else if (!is_nop) illegal = 1'b1;
      else if (!(all_idle || (b_open != '0))) illegal = 1'b1;
    end else if (!cke_prev && cke_cur && !is_nop) begin
      illegal = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      last_rd_valid <= 1'b0;
      last_rd_bank  <= 2'h0;
    end else if (sel_rd != '0) begin
      last_rd_valid <= 1'b1;
      last_rd_bank  <= ba;
    end else if (sel_bst != '0 || sel_wr != '0) begin
      last_rd_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      glb  <= GLB_NORMAL;
      gtmr <= TMR_ZERO;
    end else if (cke_prev && !cke_cur && glb == GLB_NORMAL && !illegal) begin
      if (cmd == CMD_REF) glb <= GLB_SELF_REF;
      else if (all_idle) glb <= GLB_PRE_PD;
      else glb <= GLB_ACT_PD;
    end else if (!cke_prev && cke_cur && is_nop) begin
      case (glb)
        GLB_SELF_REF: begin
          glb  <= GLB_SR_EXIT;
          gtmr <= TMR_W'(XSNR_CYC);
        end
        GLB_PRE_PD,
        GLB_ACT_PD: glb <= GLB_NORMAL;
        default: glb <= glb;
      endcase
    end else if (cmd_en && !illegal && cmd == CMD_REF) begin
      glb  <= GLB_REFRESHING;
      gtmr <= TMR_W'(RFC_CYC);
    end else if (cmd_en && !illegal && cmd == CMD_MRS) begin
      glb  <= GLB_MODE_REG;
      gtmr <= TMR_W'(MRD_CYC);
    end else if (cmd_en && !illegal && cmd == CMD_PRE && addr[AP_BIT]) begin
      glb  <= GLB_PRE_ALL;
      gtmr <= TMR_W'(RP_CYC);
    end else if (gtmr > TMR_ZERO) begin
      gtmr <= gtmr - TMR_W'(1);
    end else if (glb == GLB_SR_EXIT || glb == GLB_REFRESHING || glb == GLB_MODE_REG ||
                 glb == GLB_PRE_ALL) begin
      glb <= GLB_NORMAL;
    end
  end

  // DLL lock count after self-refresh exit gates read readiness
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      dll_cnt <= 8'h00;
    end else if (glb == GLB_SELF_REF) begin
      dll_cnt <= 8'(DLL_LOCK_CYC);
    end else if (dll_cnt != 8'h00) begin
      dll_cnt <= dll_cnt - 8'h01;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_bank_states  <= '0;
      o_glb_state    <= GLB_NORMAL;
      o_illegal      <= 1'b0;
      o_illegal_seen <= 1'b0;
      o_read_ready   <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        o_bank_states[i*4 +: 4] <= bst[i];
      end
      o_glb_state  <= glb;
      o_illegal    <= illegal;
      // sticky: only a reset clears it, as recovery needs re-init
      if (illegal) o_illegal_seen <= 1'b1;
      o_read_ready <= (glb == GLB_NORMAL) && (dll_cnt == 8'h00);
    end
  end

endmodule // ddr_cke_cmd_fsm

// ===== core/ddr_cmd_pkg.sv
/*
  Constants and types for the DDR command and bank state logic.
  Assumes a 20 MHz system clock that stands in for the memory clock.
*/
package ddr_cmd_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_RP_NS       = 15;
  localparam int unsigned T_RCD_NS      = 15;
  localparam int unsigned T_RFC_NS      = 70;
  localparam int unsigned T_MRD_NS      = 10;
  localparam int unsigned T_WR_NS       = 15;
  localparam int unsigned T_XSNR_NS     = 75;
  // least times round up, never below one cycle
  localparam int unsigned RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RFC_CYC  = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MRD_CYC  = (T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_CYC   = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned XSNR_CYC = (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLL_LOCK_CYC = 200;

  // ************************************************************
  // widths and positions
  // ************************************************************
  localparam int unsigned NUM_BANKS    = 4;
  localparam int unsigned TMR_W        = 8;
  localparam int unsigned ADDR_W       = 13;
  localparam int unsigned AP_BIT       = 10;
  localparam int unsigned BURST_LEN    = 4;
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;

  // ************************************************************
  // commands: {cs_n, ras_n, cas_n, we_n}
  // ************************************************************
  typedef enum logic [3:0] {
    CMD_ACT   = 4'h3,
    CMD_READ  = 4'h5,
    CMD_WRITE = 4'h4,
    CMD_PRE   = 4'h2,
    CMD_REF   = 4'h1,
    CMD_MRS   = 4'h0,
    CMD_BST   = 4'h6,
    CMD_NOP   = 4'h7
  } cmd_type;

  typedef enum logic [3:0] {
    BANK_IDLE,
    BANK_ACTIVATING,
    BANK_ACTIVE,
    BANK_READ,
    BANK_WRITE,
    BANK_READ_AP,
    BANK_WRITE_AP,
    BANK_PRECHARGING
  } bank_state_type;

  typedef enum logic [3:0] {
    GLB_NORMAL,
    GLB_PRE_PD,
    GLB_ACT_PD,
    GLB_SELF_REF,
    GLB_SR_EXIT,
    GLB_REFRESHING,
    GLB_MODE_REG,
    GLB_PRE_ALL
  } glb_state_type;

endpackage

// ===== verif/ddr_cke_cmd_chk.sv
/*
  Checker for the DDR command and bank state logic, bound to its top module.
  Assumes one clock and the synchronous active-low reset of that top module.
*/
`timescale 1ns/1ps
module ddr_cke_cmd_chk (
  // clock and reset
  input wire logic                                i_sys_clk,
  input wire logic                                i_rstn,
  // watched pins and state
  input wire logic                                i_cke,
  input wire logic [ddr_cmd_pkg::NUM_BANKS*4-1:0] o_bank_states,
  input wire ddr_cmd_pkg::glb_state_type          o_glb_state,
  input wire logic                                o_illegal,
  input wire logic                                o_illegal_seen,
  input wire logic                                o_read_ready
);
  import ddr_cmd_pkg::*;
  // ************************************************************
  // properties
  // ************************************************************
  localparam logic [NUM_BANKS*4-1:0] ALL_IDLE = {NUM_BANKS{BANK_IDLE}};
  wire logic [3:0] bank0 = o_bank_states[3:0];
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_all_idle;
    (o_glb_state == GLB_NORMAL) && (o_bank_states == ALL_IDLE);
  endsequence
  sequence s_pd_entry(glb_state_type g);
    (o_glb_state == g) && ($past(o_glb_state) != g);
  endsequence

  property p_sticky; $past(o_illegal_seen) |-> o_illegal_seen; endproperty
  property p_flag; o_illegal |-> ##[0:1] o_illegal_seen; endproperty
  property p_ready; o_read_ready |-> (o_glb_state == GLB_NORMAL); endproperty
  property p_act_done; (bank0 == BANK_ACTIVATING) |-> ##[1:4] (bank0 == BANK_ACTIVE); endproperty
  property p_pre_done; (bank0 == BANK_PRECHARGING) |-> ##[1:4] (bank0 == BANK_IDLE); endproperty
  property p_ap_done; (bank0 == BANK_WRITE_AP) |-> ##[1:12] (bank0 == BANK_IDLE); endproperty
  property p_ref_done; (o_glb_state == GLB_REFRESHING) |-> ##[1:6] s_all_idle; endproperty
  property p_mrs_done; (o_glb_state == GLB_MODE_REG) |-> ##[1:4] s_all_idle; endproperty
  property p_preall_done; (o_glb_state == GLB_PRE_ALL) |-> ##[1:5] s_all_idle; endproperty
  property p_act_from_idle;
    (bank0 == BANK_ACTIVATING) && ($past(bank0) != BANK_ACTIVATING) |-> ($past(bank0) == BANK_IDLE);
  endproperty
  property p_ppd_entry; s_pd_entry(GLB_PRE_PD) |-> ($past(o_bank_states) == ALL_IDLE); endproperty
  property p_apd_entry; s_pd_entry(GLB_ACT_PD) |-> ($past(o_bank_states) != ALL_IDLE); endproperty
  property p_pd_hold;
    (o_glb_state == GLB_PRE_PD) && !$past(i_cke) && !$past(i_cke, 2) |=> (o_glb_state == GLB_PRE_PD);
  endproperty

  a_sticky:      assert property (p_sticky) else $error("illegal flag cleared");
  a_flag:        assert property (p_flag) else $error("illegal not latched");
  a_ready:       assert property (p_ready) else $error("read ready outside normal");
  a_act_done:    assert property (p_act_done) else $error("activating too long");
  a_pre_done:    assert property (p_pre_done) else $error("precharging too long");
  a_ap_done:     assert property (p_ap_done) else $error("auto precharge never idle");
  a_ref_done:    assert property (p_ref_done) else $error("refresh never ended");
  a_mrs_done:    assert property (p_mrs_done) else $error("mode access never ended");
  a_preall_done: assert property (p_preall_done) else $error("precharge all not idle");
  a_act_from_idle: assert property (p_act_from_idle) else $error("activate from busy bank");
  a_ppd_entry:   assert property (p_ppd_entry) else $error("precharge power-down, row open");
  a_apd_entry:   assert property (p_apd_entry) else $error("active power-down, no row");
  a_pd_hold:     assert property (p_pd_hold) else $error("power-down left with cke low");
endmodule // ddr_cke_cmd_chk

bind ddr_cke_cmd_fsm ddr_cke_cmd_chk ddr_cke_cmd_chk_i (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cke(i_cke), .o_bank_states(o_bank_states),
  .o_glb_state(o_glb_state), .o_illegal(o_illegal), .o_illegal_seen(o_illegal_seen), .o_read_ready(o_read_ready));

// ===== verif/ddr_ctl_model.sv
/*
  Memory controller model that drives the command pins, one command per call.
  Assumes calls start just after a falling edge; all pins change at falling edges.
*/
`timescale 1ns/1ps
module ddr_ctl_model (
  // clock
  input  wire logic                           i_sys_clk,
  // command pins
  output logic                                o_cke,
  output logic                                o_cs_n,
  output logic                                o_ras_n,
  output logic                                o_cas_n,
  output logic                                o_we_n,
  output logic [1:0]                          o_bank_addr,
  output logic [ddr_cmd_pkg::ADDR_W-1:0]      o_addr
);
  import ddr_cmd_pkg::*;
  // ************************************************************
  // command issue
  // ************************************************************
  int calm = 0;
  initial begin
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h1F;
    o_bank_addr = 2'h0;
    o_addr = 13'h0000;
  end
  // cycles since cke last rose; gates commands after any exit
  always @(posedge i_sys_clk) begin
    calm <= o_cke ? calm + 1 : 0;
  end

  task automatic issue(input cmd_type c, input logic [1:0] ba, input logic [ADDR_W-1:0] a, input logic k);
    // only nop while the exit interval runs, reads wait for the lock time
    while (calm < ((c == CMD_READ) ? int'(DLL_LOCK_CYC) : int'(XSNR_CYC) + 3)) @(negedge i_sys_clk);
    // sequences come from the bench: no write over a read, no busy bank, no data, so no mask
    @(negedge i_sys_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_bank_addr = ba;
    o_addr = a;
    o_cke = k;
    @(negedge i_sys_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
    // address is don't-care under nop: keep it moving
    o_bank_addr = ~ba;
    o_addr = ~a;
  endtask

  task automatic cke_to(input logic k);
    @(negedge i_sys_clk);
    o_cke = k;
  endtask
endmodule // ddr_ctl_model

// ===== verif/tb.sv
/*
  Self-checking bench for the DDR command and bank state logic.
  Assumes the controller model drives every command pin.
*/
`timescale 1ns/1ps
module tb;
  import ddr_cmd_pkg::*;
  // ************************************************************
  // wiring
  // ************************************************************
  localparam int GLB = 4;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  wire logic cke, cs_n, ras_n, cas_n, we_n;
  wire logic [1:0] ba;
  wire logic [ADDR_W-1:0] addr;
  logic [NUM_BANKS*4-1:0] bank_states;
  glb_state_type glb_state;
  logic illegal, illegal_seen, read_ready;
  int fail_count = 0;
  int cmp_count = 0;
  always #(CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;

  ddr_ctl_model ctl_i (.i_sys_clk(i_sys_clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_bank_addr(ba), .o_addr(addr));
  ddr_cke_cmd_fsm ddr_cke_cmd_fsm_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank_addr(ba), .i_addr(addr),
    .o_bank_states(bank_states), .o_glb_state(glb_state), .o_illegal(illegal),
    .o_illegal_seen(illegal_seen), .o_read_ready(read_ready));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] st(input int i);
    return (i < NUM_BANKS) ? bank_states[i*4 +: 4] : glb_state;
  endfunction
  // poll a bank or the global state for a bounded number of cycles
  task automatic see(input int i, input logic [3:0] e, input int n);
    for (int k = 0; k < n && st(i) !== e; k++) @(negedge i_sys_clk);
    chk({12'h000, st(i)}, {12'h000, e});
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_row_cycle;
    ctl_i.issue(CMD_ACT, 2'h0, 13'h0000, 1'b1);
    see(0, BANK_ACTIVATING, 4);
    see(0, BANK_ACTIVE, 6);
    ctl_i.issue(CMD_READ, 2'h0, 13'h0010, 1'b1);
    ctl_i.issue(CMD_PRE, 2'h0, 13'h0000, 1'b1);
    see(0, BANK_READ, 4);
    see(0, BANK_PRECHARGING, 4);
    see(0, BANK_IDLE, 6);
  endtask
  task automatic t_auto_pre;
    for (int k = 0; k < 2; k++) begin
      ctl_i.issue(CMD_ACT, 2'h2, 13'h0000, 1'b1);
      see(2, BANK_ACTIVE, 8);
      ctl_i.issue(k ? CMD_READ : CMD_WRITE, 2'h2, 13'h0400, 1'b1);
      see(2, k ? BANK_READ_AP : BANK_WRITE_AP, 4);
      see(2, BANK_IDLE, 14);
    end
  endtask
  task automatic t_terminate_and_apd;
    ctl_i.issue(CMD_ACT, 2'h1, 13'h0000, 1'b1);
    see(1, BANK_ACTIVE, 8);
    ctl_i.issue(CMD_READ, 2'h1, 13'h0008, 1'b1);
    ctl_i.issue(CMD_BST, 2'h3, 13'h0000, 1'b1);
    see(1, BANK_ACTIVE, 6);
    chk({15'h0000, illegal_seen}, 16'h0000);
    ctl_i.cke_to(1'b0);
    see(GLB, GLB_ACT_PD, 5);
    ctl_i.cke_to(1'b1);
    see(GLB, GLB_NORMAL, 5);
    chk({12'h000, st(1)}, {12'h000, BANK_ACTIVE});
  endtask
  task automatic t_global;
    cmd_type c[3] = '{CMD_PRE, CMD_REF, CMD_MRS};
    glb_state_type g[3] = '{GLB_PRE_ALL, GLB_REFRESHING, GLB_MODE_REG};
    ctl_i.issue(CMD_ACT, 2'h3, 13'h0000, 1'b1);
    see(3, BANK_ACTIVE, 8);
    for (int k = 0; k < 3; k++) begin
      ctl_i.issue(c[k], 2'h0, 13'h0400, 1'b1);
      see(GLB, g[k], 4);
      see(GLB, GLB_NORMAL, 8);
      chk(bank_states, 16'h0000);
    end
  endtask
  task automatic t_power;
    ctl_i.cke_to(1'b0);
    see(GLB, GLB_PRE_PD, 5);
    repeat (4) @(negedge i_sys_clk);
    chk({12'h000, glb_state}, {12'h000, GLB_PRE_PD});
    ctl_i.cke_to(1'b1);
    see(GLB, GLB_NORMAL, 5);
    ctl_i.issue(CMD_REF, 2'h0, 13'h0000, 1'b0);
    see(GLB, GLB_SELF_REF, 5);
    ctl_i.cke_to(1'b1);
    see(GLB, GLB_SR_EXIT, 5);
    see(GLB, GLB_NORMAL, 8);
    repeat (DLL_LOCK_CYC - 20) @(negedge i_sys_clk);
    chk({15'h0000, read_ready}, 16'h0000);
    for (int k = 0; k < 40 && read_ready !== 1'b1; k++) @(negedge i_sys_clk);
    chk({15'h0000, read_ready}, 16'h0001);
  endtask
  task automatic t_illegal;
    ctl_i.issue(CMD_READ, 2'h0, 13'h0000, 1'b1);
    for (int k = 0; k < 5 && illegal !== 1'b1; k++) @(negedge i_sys_clk);
    chk({15'h0000, illegal}, 16'h0001);
    @(negedge i_sys_clk);
    chk({12'h000, st(0)}, {12'h000, BANK_IDLE});
    chk({15'h0000, illegal_seen}, 16'h0001);
  endtask

  // ************************************************************
  // sequence and watchdog
  // ************************************************************
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    t_row_cycle();
    t_auto_pre();
    t_terminate_and_apd();
    t_global();
    t_power();
    t_illegal();
    complete_run();
  end
  initial begin
    #(CLK_PERIOD_NS * 4000);
    fail_count++;
    complete_run();
  end
endmodule // tb
